/* common/misd_pkg.sv */
// Purpose: shared constants and types of the machine input signal decoder
// Assumes: one 125 MHz clock, AHB-Lite register access, 32-bit words
// Notes:   input indices address the synchronised control vector
package misd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // control input indices (synchronised vector)
  localparam int NUM_CTL        = 20;
  localparam int IN_HOME_INH    = 0;
  localparam int IN_HOME_KEY    = 1;
  localparam int IN_THREAD      = 2;
  localparam int IN_AIR         = 3;
  localparam int IN_NOOP        = 4;
  localparam int IN_START       = 5;
  localparam int IN_CLAMP       = 6;
  localparam int IN_HOME_REQ    = 7;
  localparam int IN_PRESSER     = 8;
  localparam int IN_JOG_FWD     = 9;
  localparam int IN_JOG_BWD     = 10;
  localparam int IN_HALT        = 11;
  localparam int IN_FIXED       = 12;
  localparam int IN_CLR_BOTH    = 13;
  localparam int IN_START_INH   = 14;
  localparam int IN_CLR_UP      = 15;
  localparam int IN_NEEDLE_UP   = 16;
  localparam int IN_NONSTITCH   = 17;
  localparam int IN_SEW_DONE    = 18;
  localparam int IN_HOME_DONE   = 19;
  localparam int NUM_GP         = 16;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_STATUS     = 8'h04;
  localparam logic [7:0] ADDR_ERROR      = 8'h08;
  localparam logic [7:0] ADDR_MESSAGE    = 8'h0C;
  localparam logic [7:0] ADDR_UP_COUNT   = 8'h10;
  localparam logic [7:0] ADDR_DOWN_COUNT = 8'h14;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h18;
  localparam logic [7:0] ADDR_INT_MASK   = 8'h1C;
  localparam logic [7:0] ADDR_INPUTS     = 8'h20;

  // field positions
  localparam int CTRL_THREAD_EN = 0;
  localparam int ST_STATE_LSB   = 0;
  localparam int ST_PRESSER     = 3;
  localparam int ST_FAULT       = 4;
  localparam int ST_PHASE_LSB   = 5;
  localparam int NUM_INT        = 5;
  localparam int INT_AIR        = 0;
  localparam int INT_THREAD     = 1;
  localparam int INT_MSG        = 2;
  localparam int INT_SEW_DONE   = 3;
  localparam int INT_HALT       = 4;

  // reset values and codes
  localparam logic [15:0] ERR_AIR_CODE   = 16'h3108;
  localparam logic [15:0] MSG_NONSTITCH  = 16'h0020;
  localparam logic [15:0] CODE_NONE      = 16'h0000;
  localparam logic        CTRL_RESET     = 1'b0;
  localparam logic [4:0]  MASK_RESET     = 5'h00;
  localparam logic [1:0]  PHASE_LAST     = 2'h2;

  typedef enum logic [2:0] {
    MS_IDLE,
    MS_SEWING,
    MS_HOMING,
    MS_FIXED,
    MS_MSG_WAIT,
    MS_FAULT
  } misd_mstate_t;

endpackage

/* core/misd_sync_edge.sv */
// Purpose: two-stage synchroniser with rising edge detect for pin inputs
// Assumes: inputs are asynchronous to hclk
// Notes:   edge is taken only from the second stage
`timescale 1ns/10ps
module misd_sync_edge #(
  parameter int W = 1
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
    logic [W-1:0] prev;
  } misd_sync_t;

  misd_sync_t r, n;

  always_comb begin
    n      = r;
    n.meta = pin_in;
    n.sync = r.meta;
    n.prev = r.sync;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign level = r.sync;
  assign rise  = r.sync & ~r.prev;

endmodule // misd_sync_edge

/* core/misd_decoder.sv */
// Purpose: decodes external input lines into sewing machine actions and inhibits
// Assumes: single hclk domain; all pin inputs asynchronous; AHB-Lite slave, zero wait
// Notes:   inputs act three cycles after the pin changes: two synchroniser stages, then the state register
`timescale 1ns/10ps

// Summary of operation
// - home-return requests from the panel key or the home input are ignored while homing inhibit is on.
// - the needle thread input stops sewing as a thread break only when the sensor enable bit is set.
// - low air pressure aborts everything and latches error 3108 until the next reset.
// - each general output 0 to F follows its general input.
// - while no-operation is on, no input or request other than low air pressure has any effect.
// - sew start begins sewing but is ignored while the clamp is off.
// - home return runs the homing operation, ignored while the machine runs.
// - presser foot input toggles the foot up then down on each assertion.
// - jog forward steps the table in the positive pattern direction while held.
// - jog backward steps the table in the negative pattern direction while held.
// - halt stops the machine.
// - each fixed-angle assertion advances rotation, reverse rotation, rotation with the needle held above the work.
// - after fixed-angle stepping start resumes sewing, or posts message 020 and waits for needle up and a new start.
// - counter clear zeroes both the up and the down counter.
// - start inhibit blocks the start of sewing while it is on.
// - up counter clear zeroes only the up counter.
module misd_decoder
  import misd_pkg::*;
(
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic      [31:0]        hrdata,
  output logic                    hresp,
  output logic                    irq,
  input  wire logic               homing_inhibit_input,
  input  wire logic               home_key_input,
  input  wire logic               needle_thread_break_input,
  input  wire logic               low_air_pressure_input,
  input  wire logic               no_operation_input,
  input  wire logic               sew_start_input,
  input  wire logic               clamp_on_input,
  input  wire logic               return_home_request,
  input  wire logic               presser_foot_toggle,
  input  wire logic               jog_forward_input,
  input  wire logic               jog_backward_input,
  input  wire logic               halt_input,
  input  wire logic               fixed_angle_step_input,
  input  wire logic               both_counters_clear,
  input  wire logic               start_inhibit_input,
  input  wire logic               up_count_clear,
  input  wire logic               needle_up_input,
  input  wire logic               nonstitch_next_input,
  input  wire logic               sew_cycle_done_input,
  input  wire logic               home_done_input,
  input  wire logic [NUM_GP-1:0]  general_input_n,
  output logic      [NUM_GP-1:0]  general_output_n,
  output logic                    sew_run,
  output logic                    home_run,
  output logic                    presser_up,
  output logic                    jog_fwd_run,
  output logic                    jog_bwd_run,
  output logic                    fixed_rotate,
  output logic                    fixed_reverse,
  output logic                    needle_hold_above,
  output logic                    fault_latched,
  output logic      [15:0]        error_code,
  output logic      [15:0]        message_code
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic                hreadyout;
    logic [31:0]         hrdata;
    logic                wr_pend;
    logic [7:0]          wr_addr;
    logic                thread_en;
    logic [NUM_INT-1:0]  int_st;
    logic [NUM_INT-1:0]  int_mask;
    logic                irq;
    misd_mstate_t        mstate;
    logic [1:0]          phase;
    logic [15:0]         up_cnt;
    logic [15:0]         down_cnt;
    logic [NUM_GP-1:0]   gp_out;
    logic                presser;
    logic                jog_fwd;
    logic                jog_bwd;
    logic                rot;
    logic                rev;
    logic [15:0]         err;
    logic [15:0]         msg;
    logic                sew;
    logic                home;
    logic                hold;
    logic                flt;
  } misd_regs_t;

  misd_regs_t r, n;

  logic [NUM_CTL-1:0] lvl;
  logic [NUM_CTL-1:0] rise;
  logic [NUM_GP-1:0]  gp_lvl;
  logic               take;
  logic [NUM_INT-1:0] ev;
  logic [NUM_INT-1:0] clr;
  logic               start_ok;
  logic               home_ok;

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers

  misd_sync_edge #(.W(NUM_CTL)) u_ctl_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin_in  ({home_done_input, sew_cycle_done_input, nonstitch_next_input, needle_up_input,
               up_count_clear, start_inhibit_input, both_counters_clear, fixed_angle_step_input,
               halt_input, jog_backward_input, jog_forward_input, presser_foot_toggle,
               return_home_request, clamp_on_input, sew_start_input, no_operation_input,
               low_air_pressure_input, needle_thread_break_input, home_key_input,
               homing_inhibit_input}),
    .level   (lvl),
    .rise    (rise)
  );

  misd_sync_edge #(.W(NUM_GP)) u_gp_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin_in  (general_input_n),
    .level   (gp_lvl),
    .rise    ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // register read decode

  function automatic logic [31:0] reg_read(input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (a)
      ADDR_CTRL:       d[CTRL_THREAD_EN] = r.thread_en;
      ADDR_STATUS: begin
        d[ST_STATE_LSB +: 3] = r.mstate;
        d[ST_PRESSER]        = r.presser;
        d[ST_FAULT]          = (r.mstate == MS_FAULT);
        d[ST_PHASE_LSB +: 2] = r.phase;
      end
      ADDR_ERROR:      d[15:0] = r.err;
      ADDR_MESSAGE:    d[15:0] = r.msg;
      ADDR_UP_COUNT:   d[15:0] = r.up_cnt;
      ADDR_DOWN_COUNT: d[15:0] = r.down_cnt;
      ADDR_INT_STATUS: d[NUM_INT-1:0] = r.int_st;
      ADDR_INT_MASK:   d[NUM_INT-1:0] = r.int_mask;
      ADDR_INPUTS:     d[NUM_CTL-1:0] = lvl;
      default:         d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state

  assign take     = hsel & htrans[1] & hready;
  // start needs clamp on and no start inhibit
  assign start_ok = rise[IN_START] & lvl[IN_CLAMP] & ~lvl[IN_START_INH];
  assign home_ok  = (rise[IN_HOME_REQ] | rise[IN_HOME_KEY]) & ~lvl[IN_HOME_INH];

  always_comb begin
    n           = r;
    ev          = '0;
    clr         = '0;
    n.hreadyout = 1'b1;
    n.wr_pend   = take & hwrite;
    n.wr_addr   = haddr[7:0];
    n.hrdata    = (take & ~hwrite) ? reg_read(haddr[7:0]) : 32'h0000_0000;
    n.rot       = 1'b0;
    n.rev       = 1'b0;

    if (r.wr_pend) begin
      unique case (r.wr_addr)
        ADDR_CTRL:       n.thread_en = hwdata[CTRL_THREAD_EN];
        ADDR_INT_STATUS: clr = hwdata[NUM_INT-1:0];
        ADDR_INT_MASK:   n.int_mask = hwdata[NUM_INT-1:0];
        ADDR_DOWN_COUNT: n.down_cnt = hwdata[15:0];
        default: begin
        end
      endcase
    end

    if (r.mstate == MS_FAULT) begin
      // fault holds everything off until reset
      n.jog_fwd = 1'b0;
      n.jog_bwd = 1'b0;
    end else if (lvl[IN_AIR]) begin
      n.mstate  = MS_FAULT;
      n.err     = ERR_AIR_CODE;
      n.jog_fwd = 1'b0;
      n.jog_bwd = 1'b0;
      ev[INT_AIR] = 1'b1;
    end else if (lvl[IN_NOOP]) begin
      // frozen: outputs hold, the table stops, edges seen now are dropped
      n.jog_fwd = 1'b0;
      n.jog_bwd = 1'b0;
    end else begin
      n.gp_out  = gp_lvl;
      n.jog_fwd = (r.mstate == MS_IDLE) & lvl[IN_JOG_FWD] & ~lvl[IN_JOG_BWD];
      n.jog_bwd = (r.mstate == MS_IDLE) & lvl[IN_JOG_BWD] & ~lvl[IN_JOG_FWD];
      unique case (r.mstate)
        MS_IDLE: begin
          if (start_ok) begin
            n.mstate = MS_SEWING;
          end else if (home_ok) begin
            n.mstate = MS_HOMING;
          end else if (rise[IN_FIXED]) begin
            n.mstate = MS_FIXED;
            n.phase  = 2'h0;
            n.rot    = 1'b1;
          end else if (rise[IN_PRESSER]) begin
            n.presser = ~r.presser;
          end
        end
        MS_SEWING: begin
          if (lvl[IN_HALT]) begin
            n.mstate = MS_IDLE;
            ev[INT_HALT] = 1'b1;
          end else if (r.thread_en & lvl[IN_THREAD]) begin
            n.mstate = MS_IDLE;
            ev[INT_THREAD] = 1'b1;
          end else if (rise[IN_SEW_DONE]) begin
            n.mstate = MS_IDLE;
            n.up_cnt = r.up_cnt + 16'h0001;
            n.down_cnt = (r.down_cnt == 16'h0000) ? 16'h0000 : r.down_cnt - 16'h0001;
            ev[INT_SEW_DONE] = 1'b1;
          end
        end
        MS_HOMING: begin
          if (lvl[IN_HALT]) begin
            n.mstate = MS_IDLE;
            ev[INT_HALT] = 1'b1;
          end else if (rise[IN_HOME_DONE]) begin
            n.mstate = MS_IDLE;
          end
        end
        MS_FIXED: begin
          if (lvl[IN_HALT]) begin
            n.mstate = MS_IDLE;
            ev[INT_HALT] = 1'b1;
          end else if (start_ok) begin
            if (lvl[IN_NONSTITCH]) begin
              n.mstate = MS_MSG_WAIT;
              n.msg    = MSG_NONSTITCH;
              ev[INT_MSG] = 1'b1;
            end else begin
              n.mstate = MS_SEWING;
            end
          end else if (rise[IN_FIXED]) begin
            n.phase = (r.phase == PHASE_LAST) ? 2'h0 : r.phase + 2'h1;
            n.rot   = (n.phase != 2'h1);
            n.rev   = (n.phase == 2'h1);
          end
        end
        MS_MSG_WAIT: begin
          if (lvl[IN_HALT]) begin
            n.mstate = MS_IDLE;
            n.msg    = CODE_NONE;
            ev[INT_HALT] = 1'b1;
          end else if (start_ok & lvl[IN_NEEDLE_UP]) begin
            n.mstate = MS_SEWING;
            n.msg    = CODE_NONE;
          end
        end
        MS_FAULT: begin
        end
      endcase
      // clears come last so they win over a same-cycle count
      if (rise[IN_CLR_BOTH]) begin
        n.up_cnt   = 16'h0000;
        n.down_cnt = 16'h0000;
      end else if (rise[IN_CLR_UP]) begin
        n.up_cnt   = 16'h0000;
      end
    end

    n.sew    = (n.mstate == MS_SEWING);
    n.home   = (n.mstate == MS_HOMING);
    n.hold   = (n.mstate == MS_FIXED) | (n.mstate == MS_MSG_WAIT);
    n.flt    = (n.mstate == MS_FAULT);
    // hardware set wins over a software clear in the same cycle
    n.int_st = (r.int_st & ~clr) | ev;
    n.irq    = |(n.int_st & n.int_mask);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r           <= '0;
      r.mstate    <= MS_IDLE;
      r.thread_en <= CTRL_RESET;
      r.int_mask  <= MASK_RESET;
      r.err       <= CODE_NONE;
      r.msg       <= CODE_NONE;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all but hresp (tied low) straight from the state register

  assign hreadyout         = r.hreadyout;
  assign hrdata            = r.hrdata;
  assign hresp             = 1'b0;
  assign irq               = r.irq;
  assign general_output_n  = r.gp_out;
  assign sew_run           = r.sew;
  assign home_run          = r.home;
  assign presser_up        = r.presser;
  assign jog_fwd_run       = r.jog_fwd;
  assign jog_bwd_run       = r.jog_bwd;
  assign fixed_rotate      = r.rot;
  assign fixed_reverse     = r.rev;
  assign needle_hold_above = r.hold;
  assign fault_latched     = r.flt;
  assign error_code        = r.err;
  assign message_code      = r.msg;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic active;
  assign active = (r.mstate != MS_FAULT) & ~lvl[IN_AIR] & ~lvl[IN_NOOP];

  a_home_inhibit: assert property (
    (r.mstate == MS_IDLE) && lvl[IN_HOME_INH] |=> r.mstate != MS_HOMING)
    else $error("homing started while inhibited");
  a_thread_gate: assert property (
    $rose(r.int_st[INT_THREAD]) |-> $past(r.thread_en) && $past(r.mstate) == MS_SEWING)
    else $error("thread break flagged while sensor disabled");
  a_air_fault: assert property (
    lvl[IN_AIR] |=> fault_latched && error_code == ERR_AIR_CODE ##1 fault_latched [*8])
    else $error("air fault not latched");
  a_gp_mirror: assert property (
    active |=> general_output_n == $past(gp_lvl))
    else $error("general output does not follow input");
  a_noop_freeze: assert property (
    lvl[IN_NOOP] && !lvl[IN_AIR] |=> $stable(r.mstate) && $stable(r.up_cnt) && $stable(r.presser))
    else $error("activity while no-operation is on");
  a_start_clamp: assert property (
    (r.mstate == MS_IDLE) && !lvl[IN_CLAMP] |=> !sew_run)
    else $error("sewing started with clamp off");
  a_presser_toggle: assert property (
    active && r.mstate == MS_IDLE && rise[IN_PRESSER] && !rise[IN_START] && !rise[IN_HOME_REQ]
      && !rise[IN_HOME_KEY] && !rise[IN_FIXED] |=> presser_up != $past(presser_up))
    else $error("presser foot did not toggle");
  a_jog_fwd: assert property (
    jog_fwd_run |-> $past(lvl[IN_JOG_FWD]) && !jog_bwd_run)
    else $error("jog forward without its input");
  a_halt_stop: assert property (
    active && sew_run && lvl[IN_HALT] |=> !sew_run ##1 !sew_run)
    else $error("halt did not stop sewing");
  a_fixed_seq: assert property (
    active && r.mstate == MS_FIXED && rise[IN_FIXED] && !start_ok && !lvl[IN_HALT] && r.phase == 2'h0
      |=> fixed_reverse && !fixed_rotate)
    else $error("fixed-angle sequence out of order");
  a_msg_post: assert property (
    active && r.mstate == MS_FIXED && !lvl[IN_HALT] && start_ok && lvl[IN_NONSTITCH]
      |=> message_code == MSG_NONSTITCH && !sew_run)
    else $error("non-stitch message not posted");
  a_clear_both: assert property (
    active && rise[IN_CLR_BOTH] |=> r.up_cnt == 16'h0000 && r.down_cnt == 16'h0000)
    else $error("counters not cleared");
  a_start_inhibit: assert property (
    !sew_run && lvl[IN_START_INH] |=> !sew_run)
    else $error("sewing started while inhibited");
  a_clear_up: assert property (
    active && rise[IN_CLR_UP] && !rise[IN_CLR_BOTH] && !r.wr_pend && r.mstate != MS_SEWING
      |=> r.up_cnt == 16'h0000 && $stable(r.down_cnt))
    else $error("up clear disturbed down counter");

  c_sew_done:  cover property (sew_run ##1 r.int_st[INT_SEW_DONE]);
  c_msg_wait:  cover property (r.mstate == MS_MSG_WAIT ##[1:50] sew_run);
  c_air_fault: cover property ($rose(fault_latched));
  c_homing:    cover property (home_run ##[1:50] !home_run);

endmodule // misd_decoder

/* testbench/misd_pin_partner.sv */
// Purpose: switches, sensors and controller lines facing the decoder pins
// Assumes: lines change just after a rising hclk edge
// Notes:   no pull-ups; every line is driven at all times
`timescale 1ns/10ps
module misd_pin_partner
  import misd_pkg::*;
(
  input  wire logic                hclk,
  output logic       [NUM_CTL-1:0] ctl,
  output logic       [NUM_GP-1:0]  gp
);
  initial begin
    ctl = '0;
    gp  = '0;
  end
  // every level is held 4 edges so the 2-flop synchroniser sees it once
  task automatic set(input int idx, input logic v);
    ctl[idx] <= v;
    repeat (4) @(posedge hclk);
  endtask
  // one assertion: high then low, each at least 2 cycles
  task automatic pulse(input int idx);
    set(idx, 1'b1);
    set(idx, 1'b0);
  endtask
  task automatic set_gp(input logic [NUM_GP-1:0] v);
    gp <= v;
    repeat (4) @(posedge hclk);
  endtask
endmodule // misd_pin_partner

/* testbench/tb_misd_decoder.sv */
// Purpose: self-checking bench of the input signal decoder
// Assumes: zero-wait AHB-Lite slave, pins driven by the partner model
// Notes:   checks are made after pins have settled through the synchroniser
`timescale 1ns/10ps
module tb_misd_decoder
  import misd_pkg::*;
;
  logic               hclk = 1'b0;
  logic               hresetn = 1'b0;
  logic               hsel = 1'b0;
  logic [31:0]        haddr = '0;
  logic [1:0]         htrans = 2'b00;
  logic               hwrite = 1'b0;
  logic [31:0]        hwdata = '0;
  logic               hreadyout, hresp, irq;
  logic [31:0]        hrdata;
  logic [NUM_CTL-1:0] ctl;
  logic [NUM_GP-1:0]  gp, gpo;
  logic               sew_run, home_run, presser_up, jog_fwd_run, jog_bwd_run;
  logic               fixed_rotate, fixed_reverse, needle_hold_above, fault_latched;
  logic [15:0]        error_code, message_code;
  int                 err_total = 0;
  int                 cmp_count = 0;
  int                 cyc = 0;
  int                 rot_cnt = 0;
  int                 rev_cnt = 0;

  always #4 hclk = ~hclk;

  misd_pin_partner u_misd_pin_partner (.hclk(hclk), .ctl(ctl), .gp(gp));

  misd_decoder u_misd_decoder (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .irq(irq), .homing_inhibit_input(ctl[IN_HOME_INH]), .home_key_input(ctl[IN_HOME_KEY]),
    .needle_thread_break_input(ctl[IN_THREAD]), .low_air_pressure_input(ctl[IN_AIR]),
    .no_operation_input(ctl[IN_NOOP]), .sew_start_input(ctl[IN_START]), .clamp_on_input(ctl[IN_CLAMP]),
    .return_home_request(ctl[IN_HOME_REQ]), .presser_foot_toggle(ctl[IN_PRESSER]),
    .jog_forward_input(ctl[IN_JOG_FWD]), .jog_backward_input(ctl[IN_JOG_BWD]), .halt_input(ctl[IN_HALT]),
    .fixed_angle_step_input(ctl[IN_FIXED]), .both_counters_clear(ctl[IN_CLR_BOTH]),
    .start_inhibit_input(ctl[IN_START_INH]), .up_count_clear(ctl[IN_CLR_UP]),
    .needle_up_input(ctl[IN_NEEDLE_UP]), .nonstitch_next_input(ctl[IN_NONSTITCH]),
    .sew_cycle_done_input(ctl[IN_SEW_DONE]), .home_done_input(ctl[IN_HOME_DONE]),
    .general_input_n(gp), .general_output_n(gpo), .sew_run(sew_run), .home_run(home_run),
    .presser_up(presser_up), .jog_fwd_run(jog_fwd_run), .jog_bwd_run(jog_bwd_run),
    .fixed_rotate(fixed_rotate), .fixed_reverse(fixed_reverse), .needle_hold_above(needle_hold_above),
    .fault_latched(fault_latched), .error_code(error_code), .message_code(message_code)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // the master holds each phase until hready is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    bus(1'b1, a, d, rd);
  endtask

  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, a, 32'h0000_0000, rd);
    chk(n, rd, exp);
  endtask

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    rot_cnt <= rot_cnt + (fixed_rotate === 1'b1);
    rev_cnt <= rev_cnt + (fixed_reverse === 1'b1);
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc("ctrl", ADDR_CTRL, 32'h0000_0000);
    rc("mask", ADDR_INT_MASK, 32'h0000_0000);
    rc("unmapped", 8'h24, 32'h0000_0000);
    rc("error", ADDR_ERROR, 32'h0000_0000);
    u_misd_pin_partner.set_gp(16'hA5C3);
    chk("gp out a", gpo, 32'h0000_A5C3);
    u_misd_pin_partner.set_gp(16'h5A3C);
    chk("gp out b", gpo, 32'h0000_5A3C);
    $display("test regs and mirror done");
    u_misd_pin_partner.pulse(IN_START);
    chk("start clamp off", sew_run, 32'h0);
    u_misd_pin_partner.set(IN_CLAMP, 1'b1);
    u_misd_pin_partner.set(IN_START_INH, 1'b1);
    u_misd_pin_partner.pulse(IN_START);
    chk("start inhibited", sew_run, 32'h0);
    u_misd_pin_partner.set(IN_START_INH, 1'b0);
    wr(ADDR_DOWN_COUNT, 32'h0000_0005);
    wr(ADDR_INT_MASK, 32'h0000_0008);
    u_misd_pin_partner.pulse(IN_START);
    chk("sew run", sew_run, 32'h1);
    u_misd_pin_partner.pulse(IN_SEW_DONE);
    chk("sew end", sew_run, 32'h0);
    chk("irq set", irq, 32'h1);
    rc("up 1", ADDR_UP_COUNT, 32'h0000_0001);
    rc("down 4", ADDR_DOWN_COUNT, 32'h0000_0004);
    wr(ADDR_INT_STATUS, 32'h0000_0008);
    repeat (2) @(posedge hclk);
    chk("irq clear", irq, 32'h0);
    u_misd_pin_partner.pulse(IN_CLR_UP);
    rc("up cleared", ADDR_UP_COUNT, 32'h0000_0000);
    rc("down kept", ADDR_DOWN_COUNT, 32'h0000_0004);
    u_misd_pin_partner.pulse(IN_START);
    u_misd_pin_partner.pulse(IN_SEW_DONE);
    u_misd_pin_partner.pulse(IN_CLR_BOTH);
    rc("up both", ADDR_UP_COUNT, 32'h0000_0000);
    rc("down both", ADDR_DOWN_COUNT, 32'h0000_0000);
    $display("test sewing and counters done");
    u_misd_pin_partner.set(IN_HOME_INH, 1'b1);
    u_misd_pin_partner.pulse(IN_HOME_REQ);
    chk("home inh req", home_run, 32'h0);
    u_misd_pin_partner.pulse(IN_HOME_KEY);
    chk("home inh key", home_run, 32'h0);
    u_misd_pin_partner.set(IN_HOME_INH, 1'b0);
    u_misd_pin_partner.pulse(IN_HOME_REQ);
    chk("home run", home_run, 32'h1);
    u_misd_pin_partner.pulse(IN_HOME_DONE);
    chk("home end", home_run, 32'h0);
    for (int i = 0; i < 2; i++) begin
      u_misd_pin_partner.pulse(IN_PRESSER);
      chk("presser", presser_up, 32'(1 - i));
    end
    for (int i = 0; i < 2; i++) begin
      u_misd_pin_partner.set(IN_JOG_FWD + i, 1'b1);
      chk("jog held", {jog_bwd_run, jog_fwd_run}, 32'(1 << i));
      u_misd_pin_partner.set(IN_JOG_FWD + i, 1'b0);
      chk("jog off", {jog_bwd_run, jog_fwd_run}, 32'h0);
    end
    $display("test home presser jog done");
    for (int k = 0; k < 4; k++) begin
      u_misd_pin_partner.pulse(IN_FIXED);
      rc("fixed phase", ADDR_STATUS, {25'h0, 2'(k % 3), 2'b00, 3'd3});
    end
    chk("rot count", rot_cnt, 32'd3);
    chk("rev count", rev_cnt, 32'd1);
    chk("needle above", needle_hold_above, 32'h1);
    u_misd_pin_partner.pulse(IN_START);
    chk("fixed resume", sew_run, 32'h1);
    u_misd_pin_partner.pulse(IN_HALT);
    chk("halt sewing", sew_run, 32'h0);
    u_misd_pin_partner.pulse(IN_FIXED);
    u_misd_pin_partner.set(IN_NONSTITCH, 1'b1);
    u_misd_pin_partner.pulse(IN_START);
    chk("msg code", message_code, {16'h0000, MSG_NONSTITCH});
    chk("msg no sew", sew_run, 32'h0);
    u_misd_pin_partner.pulse(IN_START);
    chk("msg needle down", sew_run, 32'h0);
    u_misd_pin_partner.set(IN_NEEDLE_UP, 1'b1);
    u_misd_pin_partner.pulse(IN_START);
    chk("msg resume", sew_run, 32'h1);
    u_misd_pin_partner.set(IN_NONSTITCH, 1'b0);
    u_misd_pin_partner.pulse(IN_HALT);
    rc("halt idle", ADDR_STATUS, 32'h0000_0000);
    $display("test fixed angle done");
    wr(ADDR_CTRL, 32'h0000_0000);
    u_misd_pin_partner.pulse(IN_START);
    u_misd_pin_partner.set(IN_THREAD, 1'b1);
    chk("thread off", sew_run, 32'h1);
    u_misd_pin_partner.set(IN_THREAD, 1'b0);
    wr(ADDR_CTRL, 32'h0000_0001);
    u_misd_pin_partner.set(IN_THREAD, 1'b1);
    chk("thread on", sew_run, 32'h0);
    u_misd_pin_partner.set(IN_THREAD, 1'b0);
    u_misd_pin_partner.set(IN_NOOP, 1'b1);
    u_misd_pin_partner.pulse(IN_PRESSER);
    chk("noop", presser_up, 32'h0);
    u_misd_pin_partner.set(IN_NOOP, 1'b0);
    u_misd_pin_partner.pulse(IN_AIR);
    chk("air fault", fault_latched, 32'h1);
    chk("air code", error_code, {16'h0000, ERR_AIR_CODE});
    u_misd_pin_partner.pulse(IN_START);
    chk("air frozen", sew_run, 32'h0);
    rc("air error", ADDR_ERROR, {16'h0000, ERR_AIR_CODE});
    $display("test thread noop air done");
    summarize();
  end
endmodule // tb_misd_decoder
